// file: pkg/pcs_pkg.sv
// Constants and types for the position compare sequencer.
// Assumes a single 25 MHz clock domain and no register bus.
package pcs_pkg;

   // ***********************************************************
   // Timing and sizes
   // ***********************************************************
   localparam int CLK_HZ          = 25000000;
   localparam int RESP_TIME_NS    = 1000;
   // Longest response in cycles, rounded down
   localparam int RESP_CYC        = (RESP_TIME_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int POS_W           = 32;
   localparam int CTRL_EN_BIT     = 0;
   localparam logic [15:0] RST_WIDTH = 16'h0019;

   // ***********************************************************
   // Sequencer states, Gray coded from idle to pulse; the pulse to load step flips both bits
   // ***********************************************************
   typedef enum logic [1:0]
   {
      PCS_IDLE  = 2'b00,
      PCS_LOAD  = 2'b01,
      PCS_WATCH = 2'b11,
      PCS_PULSE = 2'b10
   } pcs_state_t;

endpackage : pcs_pkg

// file: hw/pcs_position_compare_sequencer.sv
// Position compare sequencer: walks a table of signed 32-bit targets and
// fires one pulse on the compare pin as the axis passes each target.
// Assumes the axis position comes from logic on the same clock.
// Assumes software loads table and count before it writes the start bit;
// a count load while a run is active is ignored, not queued.
module pcs_position_compare_sequencer
   import pcs_pkg::*;
#(
   parameter int IDX_W = 8,
   parameter int CNT_W = 16
)
(
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    rstn,
   // Axis position source
   input  wire logic signed [POS_W-1:0] axis_pos,
   // Control word bit 0 write
   input  wire logic                    ctrl_wr,
   input  wire logic                    ctrl_wr_en,
   // Configuration
   input  wire logic [IDX_W-1:0]        compare_table_start_index,
   input  wire logic                    cnt_wr,
   input  wire logic [CNT_W-1:0]        cnt_wdata,
   input  wire logic                    cont_mode,
   input  wire logic                    capture_handover,
   input  wire logic                    pulse_active_low,
   input  wire logic [15:0]             pulse_width,
   // Data array write port
   input  wire logic                    tbl_wr,
   input  wire logic [IDX_W-1:0]        tbl_waddr,
   input  wire logic signed [POS_W-1:0] tbl_wdata,
   // Status and outputs
   output logic                         compare_control_en,
   output logic [CNT_W-1:0]             compare_point_count,
   output logic [IDX_W-1:0]             cur_index,
   output logic                         capture_enable,
   output logic                         compare_output_pin
);

   // ***********************************************************
   // Storage and state
   // ***********************************************************
   logic signed [POS_W-1:0] table_mem [0:(1<<IDX_W)-1];
   pcs_state_t              state_q, state_d;
   logic signed [POS_W-1:0] target_q;
   logic signed [POS_W-1:0] prev_pos_q;
   logic [CNT_W-1:0]        cnt_q, total_q;
   logic [IDX_W-1:0]        idx_q, step_q;
   logic [15:0]             width_q;
   logic                    pulse_q, en_q, cap_q;

   // ***********************************************************
   // Decode
   // ***********************************************************
   // Crossing test: previous and current sample straddle the target
   wire cross_up   = (prev_pos_q < target_q) && (axis_pos >= target_q);
   wire cross_dn   = (prev_pos_q > target_q) && (axis_pos <= target_q);
   wire hit        = (state_q == PCS_WATCH) && (cross_up || cross_dn);
   wire start_req  = ctrl_wr && ctrl_wr_en;
   wire stop_req   = ctrl_wr && !ctrl_wr_en;
   wire zero_cnt   = (cnt_q == '0);
   wire last_hit   = (step_q == total_q[IDX_W-1:0] - 1'b1);
   wire [IDX_W-1:0] next_idx = last_hit ? compare_table_start_index
                                         : idx_q + 1'b1;
   wire [15:0] width_eff = (pulse_width == 16'h0000) ? RST_WIDTH
                                                      : pulse_width;

   // Table write port; read is registered in the load state
   always_ff @(posedge clock)
   begin
      if (tbl_wr)
         table_mem[tbl_waddr] <= tbl_wdata;
   end

   // Next state; pulse starts on the hit cycle so the pin moves in 1 cycle
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         PCS_IDLE:
            if (start_req && !zero_cnt)
               state_d = PCS_LOAD;
         PCS_LOAD:
            state_d = PCS_WATCH;
         PCS_WATCH:
            if (hit)
               state_d = PCS_PULSE;
         PCS_PULSE:
            if (width_q <= 16'h0001)
            begin
               if (!en_q)
                  state_d = PCS_IDLE;
               else
                  state_d = PCS_LOAD;
            end
         default:
            state_d = PCS_IDLE;
      endcase
      if (ctrl_wr && !ctrl_wr_en)
         state_d = PCS_IDLE;
   end

   // ***********************************************************
   // Sequencer state
   // ***********************************************************
   // State register; a stop write overrides every other move
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         state_q <= PCS_IDLE;
      else
         state_q <= state_d;
   end

   // ***********************************************************
   // Target and previous position
   // ***********************************************************
   // Previous sample follows the axis every cycle, so the crossing
   // test always spans exactly one clock of travel
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         prev_pos_q <= '0;
      else
         prev_pos_q <= axis_pos;
   end

   // Target fetched in the load state; a crossing in that cycle is lost
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         target_q <= '0;
      else if (state_q == PCS_LOAD)
         target_q <= table_mem[idx_q];
   end

   // ***********************************************************
   // Point count
   // ***********************************************************
   // Loaded only while idle; continuous mode leaves it alone so the
   // run can never end by itself
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cnt_q <= '0;
      else if (cnt_wr && state_q == PCS_IDLE)
         cnt_q <= cnt_wdata;
      else if (hit && !cont_mode)
         cnt_q <= cnt_q - 1'b1;
   end

   // ***********************************************************
   // Table walk
   // ***********************************************************
   // Run length is latched at start, so the falling count does not
   // move the wrap point
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         idx_q   <= '0;
         step_q  <= '0;
         total_q <= '0;
      end
      else if (start_req && state_q == PCS_IDLE)
      begin
         idx_q   <= compare_table_start_index;
         step_q  <= '0;
         total_q <= cnt_q;
      end
      else if (hit)
      begin
         idx_q  <= next_idx;
         step_q <= last_hit ? '0 : step_q + 1'b1;
      end
   end

   // ***********************************************************
   // Output pulse
   // ***********************************************************
   // Pulse held for the width count; outside the pulse state it is
   // forced low, so a stop in mid-pulse never leaves the pin stuck
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pulse_q <= 1'b0;
         width_q <= '0;
      end
      else if (hit)
      begin
         pulse_q <= 1'b1;
         width_q <= width_eff;
      end
      else if (state_q == PCS_PULSE)
      begin
         width_q <= width_q - 16'h0001;
         if (width_q <= 16'h0001)
            pulse_q <= 1'b0;
      end
      else
         pulse_q <= 1'b0;
   end

   // ***********************************************************
   // Enable and capture hand-over
   // ***********************************************************
   // A stop write wins over a final match in the same cycle: the run
   // was cut short, so no hand-over is made
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         en_q  <= 1'b0;
         cap_q <= 1'b0;
      end
      else if (start_req && state_q == PCS_IDLE)
      begin
         en_q  <= !zero_cnt;
         cap_q <= 1'b0;
      end
      else if (stop_req)
         en_q <= 1'b0;
      else if (hit && last_hit && !cont_mode)
      begin
         en_q  <= 1'b0;
         cap_q <= capture_handover;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   // Polarity applied after the register; the pin idles at its rest level
   assign compare_output_pin  = pulse_q ^ pulse_active_low;
   assign compare_control_en  = en_q;
   assign compare_point_count = cnt_q;
   assign cur_index           = idx_q;
   assign capture_enable      = cap_q;

endmodule : pcs_position_compare_sequencer

// file: verif/pcs_axis_model.sv
// Axis position source: a counter that walks toward a goal by 4 a clock.
// Assumes the bench sets goals on multiples of 4, on the sequencer clock.
module pcs_axis_model
   import pcs_pkg::*;
(
   // Clock, reset and goal
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic signed [31:0] goal,
   // Position seen by the sequencer
   output logic signed [POS_W-1:0] axis_pos
);
   timeunit 1ns;
   timeprecision 1ns;
   // Signed 32-bit position; the counter moves, the targets are not summed
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) axis_pos <= '0;
      else if (axis_pos < goal) axis_pos <= axis_pos + 4;
      else if (axis_pos > goal) axis_pos <= axis_pos - 4;
endmodule : pcs_axis_model

// file: verif/pcs_sva.sv
// Port checker for the position compare sequencer.
// Assumes one clock domain; bound to the sequencer by name.
module pcs_sva
   import pcs_pkg::*;
#(parameter int IDX_W = 8, parameter int CNT_W = 16)
(
   // Inputs and outputs of the sequencer
   input wire logic             clock,
   input wire logic             rstn,
   input wire logic             ctrl_wr,
   input wire logic             ctrl_wr_en,
   input wire logic             cont_mode,
   input wire logic             capture_handover,
   input wire logic             pulse_active_low,
   input wire logic [15:0]      pulse_width,
   input wire logic             compare_control_en,
   input wire logic [CNT_W-1:0] compare_point_count,
   input wire logic [IDX_W-1:0] cur_index,
   input wire logic             capture_enable,
   input wire logic             compare_output_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic        act;
   logic        hit;
   logic [15:0] w_q;
   assign act = compare_output_pin ^ pulse_active_low;
   // Length of the active pulse so far, to judge the width on its end
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) w_q <= '0;
      else w_q <= act ? w_q + 16'h0001 : '0;
   chk_start_en: assert property (ctrl_wr && ctrl_wr_en && !compare_control_en
      && compare_point_count != 0 |=> compare_control_en) else $error("no start");
   chk_zero_start: assert property (ctrl_wr && ctrl_wr_en && !compare_control_en
      && compare_point_count == 0 |=> !compare_control_en) else $error("zero run");
   chk_count_step: assert property ($past(compare_control_en)
      && $changed(compare_point_count) |-> compare_point_count ==
      $past(compare_point_count) - 1'b1) else $error("count step");
   chk_index_step: assert property ($past(compare_control_en)
      && $changed(compare_point_count) && compare_point_count != 0
      |-> cur_index == $past(cur_index) + 1'b1) else $error("index step");
   chk_pulse_width: assert property ($fell(act) |-> w_q ==
      (pulse_width == 0 ? RST_WIDTH : pulse_width)) else $error("width");
   chk_hit_pulse: assert property ($past(compare_control_en)
      && $changed(compare_point_count) |-> ##[0:2] act) else $error("no pulse");
   chk_run_done: assert property ($past(compare_control_en)
      && $changed(compare_point_count) && compare_point_count == 0
      |-> ##[0:1] !compare_control_en) else $error("enable kept");
   chk_hand_over: assert property ($fell(compare_control_en)
      && compare_point_count == 0 && capture_handover && !cont_mode
      |-> ##[0:2] capture_enable) else $error("no capture");
   chk_cont_keep: assert property (cont_mode && compare_control_en
      && !(ctrl_wr && !ctrl_wr_en) |=> compare_control_en) else $error("cont");
endmodule : pcs_sva
bind pcs_position_compare_sequencer pcs_sva #(.IDX_W(IDX_W), .CNT_W(CNT_W))
   i_pcs_sva (.*);

// file: verif/testbench.sv
// Self-checking bench for the position compare sequencer.
// Assumes the axis model as the only position source.
module testbench
   import pcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rstn = 0, ctrl_wr = 0, ctrl_wr_en = 0, cnt_wr = 0;
   logic cont_mode = 0, capture_handover = 0, pulse_active_low = 0;
   logic tbl_wr = 0, act_q = 0, compare_control_en, capture_enable;
   logic compare_output_pin;
   logic [7:0] compare_table_start_index = 8'h04, tbl_waddr = 0, cur_index;
   logic [15:0] cnt_wdata = 0, pulse_width = 16'h0003, compare_point_count;
   logic signed [31:0] tbl_wdata = 0, goal = 0, axis_pos;
   int fail_count = 0, comparisons = 0, pulses = 0;
   pcs_position_compare_sequencer i_pcs_position_compare_sequencer (.*);
   pcs_axis_model i_pcs_axis_model (.*);
   always #20 clock = ~clock;
   // Count pulses at their leading edge, whatever the pin polarity
   always @(posedge clock)
   begin
      act_q <= compare_output_pin ^ pulse_active_low;
      if ((compare_output_pin ^ pulse_active_low) && !act_q) pulses++;
   end
   task automatic chk(logic [31:0] g, logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
      end
   endtask : chk
   task automatic go(logic signed [31:0] g);
      goal <= g;
      for (int i = 0; i < 200 && axis_pos !== g; i++) @(posedge clock);
      repeat (30) @(posedge clock);
   endtask : go
   task automatic wr(logic [7:0] a, logic signed [31:0] v);
      @(posedge clock);
      {tbl_wr, tbl_waddr, tbl_wdata} <= {1'b1, a, v};
      @(posedge clock);
      tbl_wr <= 0;
   endtask : wr
   task automatic start(logic [15:0] n, logic en);
      @(posedge clock);
      {cnt_wr, cnt_wdata} <= {1'b1, n};
      @(posedge clock);
      {cnt_wr, ctrl_wr, ctrl_wr_en} <= {2'b01, en};
      @(posedge clock);
      ctrl_wr <= 0;
      repeat (3) @(posedge clock);
   endtask : start
   task automatic t_run(logic h);
      {capture_handover, pulse_active_low} <= {h, h};
      wr(4, 100);
      wr(5, -48);
      start(2, 1);
      pulses = 0;
      chk(compare_output_pin, h);
      chk(compare_control_en, 1);
      go(120);
      chk(pulses, 1);
      chk({compare_point_count, cur_index}, 24'h000105);
      go(-80);
      chk(pulses, 2);
      chk({compare_point_count, compare_control_en}, 0);
      chk(capture_enable, h);
      go(0);
   endtask : t_run
   task automatic t_cont();
      {cont_mode, capture_handover, pulse_width} <= {2'b11, 16'h0000};
      start(1, 1);
      pulses = 0;
      go(120);
      go(0);
      go(120);
      chk(pulses, 3);
      chk(cur_index, 4);
      chk({compare_control_en, capture_enable}, 2'b10);
      start(1, 0);
      chk(compare_control_en, 0);
   endtask : t_cont
   task automatic give_verdict();
      $display("mismatches %0d of %0d checks", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // Watchdog well beyond the expected run of about 600 clocks
   initial
   begin
      #200000;
      fail_count++;
      give_verdict();
   end
   initial
   begin
      repeat (5) @(posedge clock);
      rstn <= 1;
      start(0, 1);
      chk(compare_control_en, 0);
      t_run(0);
      t_run(1);
      t_cont();
      give_verdict();
   end
endmodule : testbench
